// ### inc/tmr_pkg.sv
// Purpose: Shared constants, modes and carriers of the dual timer block
// Assumes: 8-bit special function register bus, one clock domain
// Notes:   Every offset, bit position and count lives here
package tmr_pkg;
   ////////////////////////////////////////////////////////////////////////
   // Register offsets
   localparam logic [7:0] TIMER_CONTROL_ADDR     = 8'h88;
   localparam logic [7:0] TIMER_MODE_SELECT_ADDR = 8'h89;
   localparam logic [7:0] TIMER0_LOW_BYTE_ADDR   = 8'h8A;
   localparam logic [7:0] TIMER1_LOW_BYTE_ADDR   = 8'h8B;
   localparam logic [7:0] TIMER0_HIGH_BYTE_ADDR  = 8'h8C;
   localparam logic [7:0] TIMER1_HIGH_BYTE_ADDR  = 8'h8D;
   localparam logic [7:0] IRQ_ENABLE_ADDR        = 8'hA8;
   localparam logic [7:0] TIMER2_CONTROL_ADDR    = 8'hC8;
   localparam logic [7:0] TIMER2_MODE_ADDR       = 8'hC9;
   localparam logic [7:0] TIMER2_RELOAD_LOW_ADDR = 8'hCA;
   localparam logic [7:0] TIMER2_RELOAD_HIGH_ADDR = 8'hCB;
   localparam logic [7:0] TIMER2_LOW_BYTE_ADDR   = 8'hCC;
   localparam logic [7:0] TIMER2_HIGH_BYTE_ADDR  = 8'hCD;
   ////////////////////////////////////////////////////////////////////////
   // Field positions
   localparam int TIMER1_OVF_BIT   = 7;
   localparam int TIMER1_RUN_BIT   = 6;
   localparam int TIMER0_OVF_BIT   = 5;
   localparam int TIMER0_RUN_BIT   = 4;
   localparam int EXT1_FLAG_BIT    = 3;
   localparam int EXT1_TYPE_BIT    = 2;
   localparam int EXT0_FLAG_BIT    = 1;
   localparam int EXT0_TYPE_BIT    = 0;
   localparam int TIMER1_GATE_BIT  = 7;
   localparam int TIMER1_SRC_BIT   = 6;
   localparam int TIMER1_MODE_LSB  = 4;
   localparam int TIMER0_GATE_BIT  = 3;
   localparam int TIMER0_SRC_BIT   = 2;
   localparam int TIMER0_MODE_LSB  = 0;
   localparam int TIMER2_OVF_BIT   = 7;
   localparam int TIMER2_EXT_BIT   = 6;
   localparam int TIMER2_RUN_BIT   = 2;
   localparam int TIMER2_SRC_BIT   = 1;
   localparam int UPDOWN_BIT       = 0;
   localparam int GLOBAL_EN_BIT    = 7;
   localparam int TIMER2_EN_BIT    = 5;
   localparam int TIMER1_EN_BIT    = 3;
   localparam int EXT1_EN_BIT      = 2;
   localparam int TIMER0_EN_BIT    = 1;
   localparam int EXT0_EN_BIT      = 0;
   ////////////////////////////////////////////////////////////////////////
   // Reset values and counts
   localparam logic [7:0]  BYTE_RESET = 8'h00;
   localparam logic [7:0]  BYTE_MAX   = 8'hFF;
   localparam logic [4:0]  LOW5_MAX   = 5'h1F;
   localparam logic [15:0] WORD_MAX   = 16'hFFFF;
   localparam logic [2:0]  PER_CLKS   = 3'h6;
   ////////////////////////////////////////////////////////////////////////
   // Modes and carriers
   typedef enum logic [1:0] {
      TMR_MODE_13     = 2'b00,
      TMR_MODE_16     = 2'b01,
      TMR_MODE_RELOAD = 2'b10,
      TMR_MODE_SPLIT  = 2'b11
   } tmr_mode_e;
   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } tmr_sfr_req_s;
   typedef struct packed {
      logic ext_irq_pin_0;
      logic ext_irq_pin_1;
      logic count_pin_0;
      logic count_pin_1;
      logic timer2_count_pin;
      logic timer2_direction_pin;
   } tmr_pins_s;
   typedef struct packed {
      logic timer0;
      logic timer1;
      logic timer2;
      logic ext0;
      logic ext1;
   } tmr_irq_s;
   typedef struct packed {
      logic [7:0] hi;
      logic [7:0] lo;
      logic       ovf;
   } tmr_cnt_s;
endpackage : tmr_pkg

// ### design/tmr_per_tick.sv
// Purpose: Peripheral cycle strobe, one clock in every six
// Assumes: Free running from reset
// Notes:   Strobe comes straight from a flip-flop
module tmr_per_tick
(
   // Clock and reset
   input  wire logic core_clk,
   input  wire logic rst,
   // Strobe
   output logic      per_tick
);
   import tmr_pkg::*;
   logic [2:0] div_cnt;

   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         div_cnt  <= 3'h0;
         per_tick <= 1'b0;
      end
      else
      begin
         div_cnt  <= (div_cnt == PER_CLKS - 3'h1) ? 3'h0 : div_cnt + 3'h1;
         per_tick <= (div_cnt == PER_CLKS - 3'h1);
      end
   end
endmodule : tmr_per_tick

// ### design/tmr_fall_sample.sv
// Purpose: Samples a count pin once per peripheral cycle, flags a fall
// Assumes: Pin is synchronous to core_clk
// Notes:   A level shorter than one peripheral cycle may be missed
module tmr_fall_sample
(
   // Clock and reset
   input  wire logic core_clk,
   input  wire logic rst,
   // Sampling
   input  wire logic sample,
   input  wire logic pin,
   output logic      fall
);
   logic last_sample;

   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         last_sample <= 1'b0;
         fall        <= 1'b0;
      end
      else
      begin
         fall <= sample & last_sample & ~pin;
         if (sample)
            last_sample <= pin;
      end
   end
endmodule : tmr_fall_sample

// ### design/tmr_dual_timer.sv
// Purpose: Timers 0 and 1 with four modes, timer 2 up/down auto-reload
// Assumes: Special function register bus, read data one clock later
// Notes:   A register write wins over counting in the same clock
module tmr_dual_timer
(
   // Clock and reset
   input  wire logic                  core_clk,
   input  wire logic                  rst,
   // Register bus
   input  wire tmr_pkg::tmr_sfr_req_s sfr_req,
   output logic [7:0]                 sfr_rdata,
   // Pins
   input  wire tmr_pkg::tmr_pins_s    pins,
   // Interrupt vectoring
   input  wire tmr_pkg::tmr_irq_s     irq_ack,
   output tmr_pkg::tmr_irq_s          irq_req
);
   import tmr_pkg::*;

   logic [7:0]  timer_control;
   logic [7:0]  timer_mode_select;
   logic [7:0]  timer0_low_byte;
   logic [7:0]  timer0_high_byte;
   logic [7:0]  timer1_low_byte;
   logic [7:0]  timer1_high_byte;
   logic [7:0]  irq_enable_reg;
   logic [7:0]  timer2_control;
   logic [7:0]  timer2_mode;
   logic [15:0] timer2_count;
   logic [15:0] timer2_reload;
   logic        per_tick;
   logic        fall0;
   logic        fall1;
   logic        fall2;
   logic        prev_ext0;
   logic        prev_ext1;
   tmr_mode_e   mode0;
   tmr_mode_e   mode1;
   logic        timer0_inc;
   logic        timer1_inc;
   logic        split_inc;
   logic        timer2_inc;
   tmr_cnt_s    next_timer0;
   tmr_cnt_s    next_timer1;
   logic        split_ovf;
   logic        set_tf0;
   logic        set_tf1;
   logic [15:0] next_timer2;
   logic        timer2_wrap;
   logic        count_down;

   ////////////////////////////////////////////////////////////////////////
   // Peripheral cycle and pin sampling
   tmr_per_tick u_tick
   (
      .core_clk (core_clk),
      .rst      (rst),
      .per_tick (per_tick)
   );

   tmr_fall_sample u_fall0
   (
      .core_clk (core_clk),
      .rst      (rst),
      .sample   (per_tick),
      .pin      (pins.count_pin_0),
      .fall     (fall0)
   );

   tmr_fall_sample u_fall1
   (
      .core_clk (core_clk),
      .rst      (rst),
      .sample   (per_tick),
      .pin      (pins.count_pin_1),
      .fall     (fall1)
   );

   tmr_fall_sample u_fall2
   (
      .core_clk (core_clk),
      .rst      (rst),
      .sample   (per_tick),
      .pin      (pins.timer2_count_pin),
      .fall     (fall2)
   );

   ////////////////////////////////////////////////////////////////////////
   // One counting step of timer 0 or 1; the split mode is handled apart
   function automatic tmr_cnt_s step(tmr_mode_e m, logic [7:0] hi,
                                     logic [7:0] lo, logic inc);
      tmr_cnt_s r;
      r = '{hi: hi, lo: lo, ovf: 1'b0};
      if (inc)
      begin
         case (m)
            TMR_MODE_13:
            begin
               // Upper three low bits are left alone, they carry no meaning
               r.lo[4:0] = lo[4:0] + 5'h01;
               if (lo[4:0] == LOW5_MAX)
               begin
                  r.hi  = hi + 8'h01;
                  r.ovf = (hi == BYTE_MAX);
               end
            end
            TMR_MODE_16:
            begin
               {r.hi, r.lo} = {hi, lo} + 16'h0001;
               r.ovf        = ({hi, lo} == WORD_MAX);
            end
            TMR_MODE_RELOAD:
            begin
               r.lo  = (lo == BYTE_MAX) ? hi : lo + 8'h01;
               r.ovf = (lo == BYTE_MAX);
            end
            default:
               r = '{hi: hi, lo: lo, ovf: 1'b0};
         endcase
      end
      return r;
   endfunction : step

   ////////////////////////////////////////////////////////////////////////
   // Count enables and steps
   always_comb
   begin
      mode0 = tmr_mode_e'(timer_mode_select[TIMER0_MODE_LSB +: 2]);
      mode1 = tmr_mode_e'(timer_mode_select[TIMER1_MODE_LSB +: 2]);
      timer0_inc = timer_control[TIMER0_RUN_BIT]
                   & (~timer_mode_select[TIMER0_GATE_BIT] | pins.ext_irq_pin_0)
                   & (timer_mode_select[TIMER0_SRC_BIT] ? fall0 : per_tick);
      // With timer 0 split, timer 1 loses its run bit and runs unless halted
      timer1_inc = ((mode0 == TMR_MODE_SPLIT) | timer_control[TIMER1_RUN_BIT])
                   & (~timer_mode_select[TIMER1_GATE_BIT] | pins.ext_irq_pin_1)
                   & (timer_mode_select[TIMER1_SRC_BIT] ? fall1 : per_tick);
      split_inc  = timer_control[TIMER1_RUN_BIT] & per_tick;
      next_timer0 = step((mode0 == TMR_MODE_SPLIT) ? TMR_MODE_RELOAD : mode0,
                         timer0_high_byte, timer0_low_byte, timer0_inc);
      split_ovf = 1'b0;
      if (mode0 == TMR_MODE_SPLIT)
      begin
         // Low byte wraps on its own, high byte is a second 8-bit timer
         next_timer0.lo = timer0_low_byte + {7'h00, timer0_inc};
         next_timer0.hi = timer0_high_byte + {7'h00, split_inc};
         split_ovf      = split_inc & (timer0_high_byte == BYTE_MAX);
      end
      next_timer1 = step(mode1, timer1_high_byte, timer1_low_byte, timer1_inc);
      set_tf0 = next_timer0.ovf;
      set_tf1 = (mode0 == TMR_MODE_SPLIT) ? split_ovf : next_timer1.ovf;
   end

   ////////////////////////////////////////////////////////////////////////
   // Timer 0 and 1 count registers
   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         timer0_low_byte  <= BYTE_RESET;
         timer0_high_byte <= BYTE_RESET;
         timer1_low_byte  <= BYTE_RESET;
         timer1_high_byte <= BYTE_RESET;
      end
      else
      begin
         timer0_low_byte  <= next_timer0.lo;
         timer0_high_byte <= next_timer0.hi;
         timer1_low_byte  <= next_timer1.lo;
         timer1_high_byte <= next_timer1.hi;
         if (sfr_req.wr)
         begin
            case (sfr_req.addr)
               TIMER0_LOW_BYTE_ADDR:  timer0_low_byte  <= sfr_req.wdata;
               TIMER0_HIGH_BYTE_ADDR: timer0_high_byte <= sfr_req.wdata;
               TIMER1_LOW_BYTE_ADDR:  timer1_low_byte  <= sfr_req.wdata;
               TIMER1_HIGH_BYTE_ADDR: timer1_high_byte <= sfr_req.wdata;
               default: ;
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Control register; a hardware set beats a software or vector clear
   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         timer_control <= BYTE_RESET;
         prev_ext0     <= 1'b1;
         prev_ext1     <= 1'b1;
      end
      else
      begin
         prev_ext0 <= pins.ext_irq_pin_0;
         prev_ext1 <= pins.ext_irq_pin_1;
         if (sfr_req.wr && sfr_req.addr == TIMER_CONTROL_ADDR)
            timer_control <= sfr_req.wdata;
         else
         begin
            if (irq_ack.timer0)
               timer_control[TIMER0_OVF_BIT] <= 1'b0;
            if (irq_ack.timer1)
               timer_control[TIMER1_OVF_BIT] <= 1'b0;
            if (irq_ack.ext0 && timer_control[EXT0_TYPE_BIT])
               timer_control[EXT0_FLAG_BIT] <= 1'b0;
            if (irq_ack.ext1 && timer_control[EXT1_TYPE_BIT])
               timer_control[EXT1_FLAG_BIT] <= 1'b0;
         end
         if (set_tf0)
            timer_control[TIMER0_OVF_BIT] <= 1'b1;
         if (set_tf1)
            timer_control[TIMER1_OVF_BIT] <= 1'b1;
         // Level mode: the flag follows the pin, low means pending
         if (!timer_control[EXT0_TYPE_BIT])
            timer_control[EXT0_FLAG_BIT] <= ~pins.ext_irq_pin_0;
         else if (prev_ext0 && !pins.ext_irq_pin_0)
            timer_control[EXT0_FLAG_BIT] <= 1'b1;
         if (!timer_control[EXT1_TYPE_BIT])
            timer_control[EXT1_FLAG_BIT] <= ~pins.ext_irq_pin_1;
         else if (prev_ext1 && !pins.ext_irq_pin_1)
            timer_control[EXT1_FLAG_BIT] <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Plain configuration registers
   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         timer_mode_select <= BYTE_RESET;
         irq_enable_reg    <= BYTE_RESET;
         timer2_mode       <= BYTE_RESET;
         timer2_reload     <= {BYTE_RESET, BYTE_RESET};
      end
      else if (sfr_req.wr)
      begin
         case (sfr_req.addr)
            TIMER_MODE_SELECT_ADDR:  timer_mode_select     <= sfr_req.wdata;
            IRQ_ENABLE_ADDR:         irq_enable_reg        <= sfr_req.wdata;
            TIMER2_MODE_ADDR:        timer2_mode           <= sfr_req.wdata;
            TIMER2_RELOAD_LOW_ADDR:  timer2_reload[7:0]    <= sfr_req.wdata;
            TIMER2_RELOAD_HIGH_ADDR: timer2_reload[15:8]   <= sfr_req.wdata;
            default: ;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Timer 2 auto-reload counter
   always_comb
   begin
      timer2_inc = timer2_control[TIMER2_RUN_BIT]
                   & (timer2_control[TIMER2_SRC_BIT] ? fall2 : per_tick);
      count_down = timer2_mode[UPDOWN_BIT] & ~pins.timer2_direction_pin;
      next_timer2 = timer2_count;
      timer2_wrap = 1'b0;
      if (timer2_inc)
      begin
         if (count_down)
         begin
            timer2_wrap = (timer2_count == timer2_reload);
            next_timer2 = timer2_wrap ? WORD_MAX : timer2_count - 16'h0001;
         end
         else
         begin
            timer2_wrap = (timer2_count == WORD_MAX);
            next_timer2 = timer2_wrap ? timer2_reload : timer2_count + 16'h0001;
         end
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         timer2_count   <= {BYTE_RESET, BYTE_RESET};
         timer2_control <= BYTE_RESET;
      end
      else
      begin
         timer2_count <= next_timer2;
         if (sfr_req.wr && sfr_req.addr == TIMER2_LOW_BYTE_ADDR)
            timer2_count[7:0] <= sfr_req.wdata;
         if (sfr_req.wr && sfr_req.addr == TIMER2_HIGH_BYTE_ADDR)
            timer2_count[15:8] <= sfr_req.wdata;
         if (sfr_req.wr && sfr_req.addr == TIMER2_CONTROL_ADDR)
            timer2_control <= sfr_req.wdata;
         if (timer2_wrap)
         begin
            timer2_control[TIMER2_OVF_BIT] <= 1'b1;
            // Toggle gives a 17th count bit; it raises no interrupt
            if (timer2_mode[UPDOWN_BIT])
               timer2_control[TIMER2_EXT_BIT] <= ~timer2_control[TIMER2_EXT_BIT];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Interrupt requests and read data
   always_ff @(posedge core_clk)
   begin
      if (rst)
         irq_req <= '0;
      else
      begin
         irq_req.timer0 <= irq_enable_reg[GLOBAL_EN_BIT] & irq_enable_reg[TIMER0_EN_BIT]
                           & timer_control[TIMER0_OVF_BIT];
         irq_req.timer1 <= irq_enable_reg[GLOBAL_EN_BIT] & irq_enable_reg[TIMER1_EN_BIT]
                           & timer_control[TIMER1_OVF_BIT];
         irq_req.timer2 <= irq_enable_reg[GLOBAL_EN_BIT] & irq_enable_reg[TIMER2_EN_BIT]
                           & timer2_control[TIMER2_OVF_BIT];
         irq_req.ext0   <= irq_enable_reg[GLOBAL_EN_BIT] & irq_enable_reg[EXT0_EN_BIT]
                           & timer_control[EXT0_FLAG_BIT];
         irq_req.ext1   <= irq_enable_reg[GLOBAL_EN_BIT] & irq_enable_reg[EXT1_EN_BIT]
                           & timer_control[EXT1_FLAG_BIT];
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (rst)
         sfr_rdata <= BYTE_RESET;
      else if (sfr_req.rd)
      begin
         case (sfr_req.addr)
            TIMER_CONTROL_ADDR:      sfr_rdata <= timer_control;
            TIMER_MODE_SELECT_ADDR:  sfr_rdata <= timer_mode_select;
            TIMER0_LOW_BYTE_ADDR:    sfr_rdata <= timer0_low_byte;
            TIMER0_HIGH_BYTE_ADDR:   sfr_rdata <= timer0_high_byte;
            TIMER1_LOW_BYTE_ADDR:    sfr_rdata <= timer1_low_byte;
            TIMER1_HIGH_BYTE_ADDR:   sfr_rdata <= timer1_high_byte;
            IRQ_ENABLE_ADDR:         sfr_rdata <= irq_enable_reg;
            TIMER2_CONTROL_ADDR:     sfr_rdata <= timer2_control;
            TIMER2_MODE_ADDR:        sfr_rdata <= timer2_mode;
            TIMER2_RELOAD_LOW_ADDR:  sfr_rdata <= timer2_reload[7:0];
            TIMER2_RELOAD_HIGH_ADDR: sfr_rdata <= timer2_reload[15:8];
            TIMER2_LOW_BYTE_ADDR:    sfr_rdata <= timer2_count[7:0];
            TIMER2_HIGH_BYTE_ADDR:   sfr_rdata <= timer2_count[15:8];
            default:                 sfr_rdata <= BYTE_RESET;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Assertions
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);

   property p_t1_reload;
      (mode1 == TMR_MODE_RELOAD) && (mode0 != TMR_MODE_SPLIT) && timer1_inc
      && timer1_low_byte == BYTE_MAX && !sfr_req.wr
      |=> timer1_low_byte == $past(timer1_high_byte) && timer_control[TIMER1_OVF_BIT]
          && $stable(timer1_high_byte);
   endproperty
   a_t1_reload: assert property (p_t1_reload) else $error("reload failed");

   property p_t1_halt;
      (mode1 == TMR_MODE_SPLIT) && !sfr_req.wr [*2]
      |-> $stable({timer1_high_byte, timer1_low_byte});
   endproperty
   a_t1_halt: assert property (p_t1_halt) else $error("halted timer moved");

   property p_ack_clear;
      irq_ack.timer0 && !set_tf0 && !sfr_req.wr |=> !timer_control[TIMER0_OVF_BIT];
   endproperty
   a_ack_clear: assert property (p_ack_clear) else $error("flag not cleared");

   property p_irq_gate;
      irq_req.timer0 |-> $past(irq_enable_reg[GLOBAL_EN_BIT]
                         && irq_enable_reg[TIMER0_EN_BIT] && timer_control[TIMER0_OVF_BIT]);
   endproperty
   a_irq_gate: assert property (p_irq_gate) else $error("ungated irq");

   property p_run_off;
      !timer_control[TIMER0_RUN_BIT] && !sfr_req.wr
      |=> $stable({timer0_high_byte, timer0_low_byte}) || $past(split_inc);
   endproperty
   a_run_off: assert property (p_run_off) else $error("stopped timer moved");

   property p_tf0_set;
      set_tf0 |=> timer_control[TIMER0_OVF_BIT];
   endproperty
   a_tf0_set: assert property (p_tf0_set) else $error("overflow lost");

   property p_edge_flag;
      timer_control[EXT0_TYPE_BIT] && prev_ext0 && !pins.ext_irq_pin_0
      |=> timer_control[EXT0_FLAG_BIT];
   endproperty
   a_edge_flag: assert property (p_edge_flag) else $error("edge missed");

   property p_level_flag;
      !timer_control[EXT0_TYPE_BIT]
      |=> timer_control[EXT0_FLAG_BIT] == !$past(pins.ext_irq_pin_0);
   endproperty
   a_level_flag: assert property (p_level_flag) else $error("level wrong");

   property p_t2_up;
      timer2_inc && !count_down && timer2_count == WORD_MAX
      && !sfr_req.wr |=> timer2_count == $past(timer2_reload)
      && timer2_control[TIMER2_OVF_BIT];
   endproperty
   a_t2_up: assert property (p_t2_up) else $error("up reload wrong");

   property p_t2_down;
      timer2_inc && count_down && timer2_count == timer2_reload
      && !sfr_req.wr |=> timer2_count == WORD_MAX
      && timer2_control[TIMER2_EXT_BIT] != $past(timer2_control[TIMER2_EXT_BIT]);
   endproperty
   a_t2_down: assert property (p_t2_down) else $error("underflow wrong");

   property p_tick;
      per_tick |=> !per_tick [*5] ##1 per_tick;
   endproperty
   a_tick: assert property (p_tick) else $error("tick spacing");

   c_split: cover property (mode0 == TMR_MODE_SPLIT && split_ovf);
   c_t2_down: cover property (count_down && timer2_wrap);
   c_t0_13: cover property (mode0 == TMR_MODE_13 && set_tf0);
   c_pin_count: cover property (fall1 && timer1_inc);
endmodule : tmr_dual_timer

// ### verif/tmr_cpu_model.sv
// Purpose: CPU core side: register cycles and vector acks
// Assumes: Tasks are entered just after a rising edge
// Notes:   Ack skips two edges so one timer 0, timer 1 or edge-mode external request gets one ack
module tmr_cpu_model
(
   // Clock
   input  wire logic           core_clk,
   // Bus
   output tmr_pkg::tmr_sfr_req_s sfr_req,
   input  wire logic [7:0]     sfr_rdata,
   // Vectoring
   input  wire tmr_pkg::tmr_irq_s irq_req,
   input  wire logic           ack_en,
   output tmr_pkg::tmr_irq_s   irq_ack
);
   timeunit 1ns;
   timeprecision 1ns;
   import tmr_pkg::*;
   tmr_irq_s ack_d;
   initial sfr_req = '0;
   initial irq_ack = '0;
   // irq_req of timer 0, timer 1 or an edge-mode external flag falls two edges after its ack
   always @(posedge core_clk)
   begin
      ack_d   <= irq_ack;
      irq_ack <= ack_en ? irq_req & ~irq_ack & ~ack_d : '0;
   end
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      sfr_req <= '{1'b1, 1'b0, a, d};
      @(posedge core_clk);
      sfr_req.wr <= 1'b0;
      @(posedge core_clk);
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      sfr_req <= '{1'b0, 1'b1, a, 8'h00};
      @(posedge core_clk);
      sfr_req.rd <= 1'b0;
      @(posedge core_clk);
      d = sfr_rdata;
   endtask : rd
endmodule : tmr_cpu_model

// ### verif/testbench.sv
// Purpose: Self-checking bench of the dual timer
// Assumes: Count pins held 12 clocks per level
// Notes:   Counter mode keeps every count exact
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   import tmr_pkg::*;
   logic         core_clk;
   logic         rst;
   logic         ack_en;
   tmr_sfr_req_s sfr_req;
   logic [7:0]   sfr_rdata;
   tmr_pins_s    pins;
   tmr_irq_s     irq_ack;
   tmr_irq_s     irq_req;
   int           n_fail;
   int           check_count;
   int           r;
   int           k;
   logic [7:0]   d;
   tmr_dual_timer dut_u (.core_clk(core_clk), .rst(rst), .sfr_req(sfr_req),
      .sfr_rdata(sfr_rdata), .pins(pins), .irq_ack(irq_ack), .irq_req(irq_req));
   tmr_cpu_model cpu_u (.core_clk(core_clk), .sfr_req(sfr_req), .sfr_rdata(sfr_rdata),
      .irq_req(irq_req), .ack_en(ack_en), .irq_ack(irq_ack));
   ////////////////////////////////////////////////////////////////////////
   task automatic chk(input string w, input logic [7:0] s, input logic [7:0] e);
      check_count++;
      if (s !== e)
      begin
         n_fail++;
         $display("wrong value %s exp %h seen %h", w, e, s);
      end
   endtask : chk
   task automatic rchk(input logic [7:0] a, input int e);
      cpu_u.rd(a, d);
      chk($sformatf("reg %h", a), d, 8'(e));
   endtask : rchk
   task automatic falls(input int b, input int n);
      repeat (n)
      begin
         pins[b] <= 1'b0;
         repeat (12) @(posedge core_clk);
         pins[b] <= 1'b1;
         repeat (12) @(posedge core_clk);
      end
   endtask : falls
   task automatic stop_test;
      $display("checks %0d fails %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : stop_test
   ////////////////////////////////////////////////////////////////////////
   initial
   begin
      core_clk = 0;
      forever #5 core_clk = ~core_clk;
   end
   initial
   begin
      #200000;
      n_fail++;
      stop_test;
   end
   initial
   begin
      rst = 1;
      ack_en = 0;
      pins = '1;
      n_fail = 0;
      check_count = 0;
      r = $urandom(16);
      repeat (16) @(posedge core_clk);
      rst <= 0;
      @(posedge core_clk);
      rchk(8'h8A, 0);
      rchk(8'h8C, 0);
      rchk(8'h80, 0);
      r = $urandom_range(239, 0);
      k = $urandom_range(5, 1);
      cpu_u.wr(8'h8B, 8'hFF);
      cpu_u.wr(8'h8D, 8'(r));
      cpu_u.wr(8'h89, 8'h60);
      cpu_u.wr(8'h88, 8'h40);
      falls(2, 1);
      rchk(8'h8B, r);
      rchk(8'h8D, r);
      rchk(8'h88, 8'hC0);
      falls(2, k);
      rchk(8'h8B, r + k);
      cpu_u.wr(8'h89, 8'h70);
      falls(2, 3);
      rchk(8'h8B, r + k);
      $display("timer 1 done");
      cpu_u.wr(8'h8A, 8'h1F);
      cpu_u.wr(8'h8C, 8'hFF);
      cpu_u.wr(8'h89, 8'h04);
      cpu_u.wr(8'hA8, 8'h02);
      cpu_u.wr(8'h88, 8'h10);
      falls(3, 1);
      rchk(8'h8C, 0);
      rchk(8'h8A, 0);
      rchk(8'h88, 8'h30);
      chk("irq_req.timer0", 8'(irq_req.timer0), 8'h00);
      cpu_u.wr(8'hA8, 8'h82);
      @(posedge core_clk);
      chk("irq_req.timer0", 8'(irq_req.timer0), 8'h01);
      ack_en <= 1;
      repeat (6) @(posedge core_clk);
      ack_en <= 0;
      rchk(8'h88, 8'h10);
      $display("timer 0 done");
      cpu_u.wr(8'h89, 8'h0D);
      pins.ext_irq_pin_0 <= 1'b0;
      falls(3, 2);
      rchk(8'h8A, 0);
      rchk(8'h88, 8'h12);
      pins.ext_irq_pin_0 <= 1'b1;
      cpu_u.wr(8'h88, 8'h11);
      pins.ext_irq_pin_0 <= 1'b0;
      // The fall is seen one edge later; reading sooner returns the old flag
      @(posedge core_clk);
      rchk(8'h88, 8'h13);
      pins.ext_irq_pin_0 <= 1'b1;
      falls(3, 2);
      rchk(8'h8A, 2);
      $display("gating done");
      cpu_u.wr(8'h8A, 8'hFF);
      cpu_u.wr(8'h8C, 8'hFF);
      cpu_u.wr(8'h89, 8'h37);
      cpu_u.wr(8'h88, 8'h10);
      falls(3, 1);
      rchk(8'h8A, 0);
      rchk(8'h8C, 8'hFF);
      rchk(8'h88, 8'h30);
      // Exactly one peripheral tick falls in the six edges before the read
      cpu_u.wr(8'h88, 8'h50);
      repeat (5) @(posedge core_clk);
      rchk(8'h8C, 0);
      rchk(8'h88, 8'hD0);
      $display("split done");
      r = $urandom_range(65535, 0);
      cpu_u.wr(8'hCA, 8'(r));
      cpu_u.wr(8'hCB, 8'(r >> 8));
      cpu_u.wr(8'hCC, 8'(r));
      cpu_u.wr(8'hCD, 8'(r >> 8));
      cpu_u.wr(8'hC9, 8'h01);
      pins.timer2_direction_pin <= 1'b0;
      cpu_u.wr(8'hC8, 8'h06);
      falls(1, 1);
      rchk(8'hCC, 8'hFF);
      rchk(8'hCD, 8'hFF);
      rchk(8'hC8, 8'hC6);
      pins.timer2_direction_pin <= 1'b1;
      falls(1, 1);
      rchk(8'hCC, r);
      rchk(8'hCD, r >> 8);
      rchk(8'hC8, 8'h86);
      cpu_u.wr(8'hC9, 8'h00);
      pins.timer2_direction_pin <= 1'b0;
      cpu_u.wr(8'hCC, 8'hFF);
      cpu_u.wr(8'hCD, 8'hFF);
      falls(1, 1);
      rchk(8'hCC, r);
      rchk(8'hCD, r >> 8);
      rchk(8'hC8, 8'h86);
      cpu_u.wr(8'hA8, 8'hA0);
      @(posedge core_clk);
      chk("irq_req.timer2", 8'(irq_req.timer2), 8'h01);
      $display("timer 2 done");
      stop_test;
   end
endmodule : testbench
